/* File: stm_map.svh */
`ifndef STM_MAP_SVH
`define STM_MAP_SVH

// register addresses, word wide
`define ADDR_RUN     3'h0
`define ADDR_CTRL    3'h1
`define ADDR_COUNT   3'h2
`define ADDR_CMP_A   3'h3
`define ADDR_CMP_P   3'h4
`define ADDR_FLAGS   3'h5

// run register
`define BIT_RUN      0

// control register fields
`define BIT_CCLR     0
`define BIT_DPX      1
`define BIT_POL      2
`define BIT_OC       3
`define FLD_IO_LO    4
`define FLD_IO_HI    5
`define FLD_MODE_LO  6
`define FLD_MODE_HI  7
`define CTRL_W       8

// flag register
`define BIT_FLAG_A   0
`define BIT_FLAG_P   1

// reset values
`define CTRL_RESET   8'h00

`endif

/* File: stm_pkg.sv */
package stm_pkg;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } mode_t;

   // compare mode: none/low/high/toggle; pwm mode: inactive/active/wave/hold
   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } pin_action_t;

endpackage

/* File: standard_timer_module.sv */
// Overview of operation
// - mode field selects compare-match 00, timer 11, PWM 10 with pin action 10.
// - compare mode, clear-source low: clear on P match or overflow; raise A and P flags.
// - compare mode, clear-source high: clear on A match; never raise P flag.
// - compare A zero in compare mode, clear-source high: counter overflows at maximum, no A flag.
// - compare mode pin changes only on comparator A match; P match leaves it.
// - on A match the pin action drives high, low, toggles, or holds.
// - counter-run rising edge loads pin level from output initial level bit.
// - timer mode counts and flags like compare mode, pin not driven.
// - PWM ignores clear-source; swap bit chooses period and duty comparator.
// - PWM raises A flag on each A match and P flag on P match.
// - PWM pin action enables wave or forces level; polarity and invert apply.
// - 10-bit, swap 0: period is P code times 128, code 0 is 1024.
// - 10-bit, swap 1: period from compare A, duty P code times 128.
// - 16-bit, swap 0: period P times 256, zero means 65536; duty compare A.
// - duty at or above period gives continuously active output.
// - run rising clears counter; run falling stops counter holding its value.
// - compare P matches only counter top bits, coarse step multiples.
// - instance 0 uses 10-bit counter and compare A, instance 1 16-bit.
`include "stm_map.svh"
`timescale 1ns/1ps
`default_nettype none

module standard_timer_module
   import stm_pkg::*;
#(
   parameter int CNT_W  = 10,
   parameter int P_W    = 3,
   parameter int DATA_W = 16
)
(
   input  wire logic              mclk_i,
   input  wire logic              rst_b_i,
   input  wire logic [2:0]        addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic                   pin_o,
   output logic                   pin_oe_o,
   output logic                   match_a_flag_o,
   output logic                   match_p_flag_o
);

   typedef struct packed {
      logic                   run;
      logic [`CTRL_W-1:0]     ctrl;
      logic [CNT_W-1:0]       cnt;
      logic [CNT_W-1:0]       cmp_a;
      logic [P_W-1:0]         cmp_p;
      logic                   flag_a;
      logic                   flag_p;
      logic                   lvl;
      logic                   pin;
      logic                   oe;
      logic [DATA_W-1:0]      rdata;
   } state_t;

   state_t s;
   state_t next_s;

   // value one below a compare setting, for last-count-before-clear tests
   function automatic logic [CNT_W-1:0] below_a(input logic [CNT_W-1:0] v);
      below_a = v - {{(CNT_W-1){1'b0}}, 1'b1};
   endfunction

   function automatic logic [P_W-1:0] below_p(input logic [P_W-1:0] v);
      below_p = v - {{(P_W-1){1'b0}}, 1'b1};
   endfunction

   mode_t         mode;
   pin_action_t   act;
   logic          cclr;
   logic          dpx;
   logic          pol;
   logic          oc;
   logic          is_pwm;
   logic [P_W-1:0] cnt_top;
   logic          low_full;
   logic          a_hit;
   logic          p_hit;
   logic          clr_on_a;
   logic          wave_active;

   assign mode     = mode_t'(s.ctrl[`FLD_MODE_HI:`FLD_MODE_LO]);
   assign act      = pin_action_t'(s.ctrl[`FLD_IO_HI:`FLD_IO_LO]);
   assign cclr     = s.ctrl[`BIT_CCLR];
   assign dpx      = s.ctrl[`BIT_DPX];
   assign pol      = s.ctrl[`BIT_POL];
   assign oc       = s.ctrl[`BIT_OC];
   assign is_pwm   = (mode == MODE_PWM);
   assign cnt_top  = s.cnt[CNT_W-1 -: P_W];
   assign low_full = &s.cnt[CNT_W-P_W-1:0];
   // match one count early so the clear lands on the compare value
   // zero compare A never matches
   assign a_hit    = s.run && (s.cmp_a != '0) && (s.cnt == below_a(s.cmp_a));
   // P match at step boundary; P zero hits at the counter maximum
   assign p_hit    = s.run && low_full && (cnt_top == below_p(s.cmp_p));
   // clear source from swap bit in pwm
   // capture mode counts like compare mode; no capture path here
   assign clr_on_a = is_pwm ? dpx : cclr;

   // duty from compare A when swap is 0, period set by P
   // duty of P steps, code 0 is a full count
   // same layout on the 16-bit instance, 256-clock steps
   always_comb
   begin
      if (dpx)
      begin
         wave_active = (s.cmp_p == '0) || (cnt_top < s.cmp_p);
      end
      else
      begin
         wave_active = (s.cnt < s.cmp_a);
      end
   end

   always_comb
   begin
      next_s       = s;
      next_s.rdata = '0;

      // counting; wrap past the maximum is the overflow clear
      if (s.run)
      begin
         if (clr_on_a ? a_hit : p_hit)
         begin
            next_s.cnt = '0;
         end
         else
         begin
            next_s.cnt = s.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end

      // compare-mode pin moves only on A match
      if (mode == MODE_COMPARE && a_hit)
      begin
         unique case (act)
            ACT_NONE:   next_s.lvl = s.lvl;
            ACT_LOW:    next_s.lvl = 1'b0;
            ACT_HIGH:   next_s.lvl = 1'b1;
            ACT_TOGGLE: next_s.lvl = ~s.lvl;
         endcase
      end

      // pwm pin action, oc picks active level
      if (is_pwm)
      begin
         unique case (act)
            ACT_NONE:   next_s.lvl = ~oc;
            ACT_LOW:    next_s.lvl = oc;
            ACT_HIGH:   next_s.lvl = wave_active ? oc : ~oc;
            ACT_TOGGLE: next_s.lvl = s.lvl;
         endcase
      end

      // register writes
      if (wr_i)
      begin
         unique case (addr_i)
            `ADDR_RUN:
            begin
               next_s.run = wdata_i[`BIT_RUN];
               // pin back to its initial level
               if (wdata_i[`BIT_RUN] && !s.run)
               begin
                  next_s.cnt = '0;
                  next_s.lvl = oc;
               end
            end
            `ADDR_CTRL:  next_s.ctrl  = wdata_i[`CTRL_W-1:0];
            `ADDR_CMP_A: next_s.cmp_a = CNT_W'(wdata_i);
            `ADDR_CMP_P: next_s.cmp_p = P_W'(wdata_i);
            `ADDR_FLAGS:
            begin
               if (wdata_i[`BIT_FLAG_A])
               begin
                  next_s.flag_a = 1'b0;
               end
               if (wdata_i[`BIT_FLAG_P])
               begin
                  next_s.flag_p = 1'b0;
               end
            end
            default:     next_s.run = s.run;
         endcase
      end

      // set after clear so a same-cycle event wins
      if (a_hit)
      begin
         next_s.flag_a = 1'b1;
      end
      // no P flag while A clears in compare or timer mode
      if (p_hit && (is_pwm || !cclr))
      begin
         next_s.flag_p = 1'b1;
      end

      // timer mode leaves the pin undriven
      next_s.oe  = (next_s.ctrl[`FLD_MODE_HI:`FLD_MODE_LO] == MODE_COMPARE)
                || (next_s.ctrl[`FLD_MODE_HI:`FLD_MODE_LO] == MODE_PWM);
      next_s.pin = next_s.lvl ^ next_s.ctrl[`BIT_POL];

      if (rd_i)
      begin
         unique case (addr_i)
            `ADDR_RUN:   next_s.rdata = DATA_W'(s.run);
            `ADDR_CTRL:  next_s.rdata = DATA_W'(s.ctrl);
            `ADDR_COUNT: next_s.rdata = DATA_W'(s.cnt);
            `ADDR_CMP_A: next_s.rdata = DATA_W'(s.cmp_a);
            `ADDR_CMP_P: next_s.rdata = DATA_W'(s.cmp_p);
            `ADDR_FLAGS: next_s.rdata = DATA_W'({s.flag_p, s.flag_a});
            default:     next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s      <= '0;
         s.ctrl <= `CTRL_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rdata_o        = s.rdata;
   assign pin_o          = s.pin;
   assign pin_oe_o       = s.oe;
   assign match_a_flag_o = s.flag_a;
   assign match_p_flag_o = s.flag_p;

   // checks on the block's own behaviour
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   run_clear_a: assert property ($rose(s.run) |-> s.cnt == '0)
      else $error("counter not zero after run rose");

   stop_hold_a: assert property (!s.run && !$past(s.run) |-> $stable(s.cnt))
      else $error("stopped counter moved");

   flag_a_set_a: assert property (a_hit |=> s.flag_a)
      else $error("A flag missed a match");

   no_p_flag_a: assert property (p_hit && !is_pwm && cclr && !s.flag_p |=> !s.flag_p)
      else $error("P flag raised with A clear source");

   a_zero_a: assert property (s.cmp_a == '0 && !s.flag_a |=> !s.flag_a)
      else $error("A flag raised with zero compare A");

   timer_pin_a: assert property (mode == MODE_TIMER && !wr_i |=> !pin_oe_o)
      else $error("pin driven in timer mode");

   cm_pin_hold_a: assert property (mode == MODE_COMPARE && !a_hit && !wr_i |=> $stable(s.lvl))
      else $error("compare pin moved without A match");

   clear_p_a: assert property (!is_pwm && !cclr && p_hit && !wr_i |=> s.cnt == '0)
      else $error("counter not cleared on P match");

   full_duty_a: assert property (is_pwm && act == ACT_HIGH && !dpx && s.cmp_p != '0
      && s.cmp_a >= {s.cmp_p, {(CNT_W-P_W){1'b0}}} && !wr_i |=> s.lvl == oc)
      else $error("duty above period not fully active");

   pwm_force_a: assert property (is_pwm && act == ACT_LOW && !wr_i |=> ##1 pin_o == (oc ^ pol))
      else $error("forced active level wrong");

   pin_init_a: assert property ($rose(s.run) |-> s.lvl == oc)
      else $error("pin level not initial after run rose");

   act_high_a: assert property (mode == MODE_COMPARE && a_hit && act == ACT_HIGH && !wr_i |=> s.lvl)
      else $error("pin not driven high on A match");

   act_low_a: assert property (mode == MODE_COMPARE && a_hit && act == ACT_LOW && !wr_i |=> !s.lvl)
      else $error("pin not driven low on A match");

   act_toggle_a: assert property (mode == MODE_COMPARE && a_hit && act == ACT_TOGGLE && !wr_i
      |=> s.lvl != $past(s.lvl))
      else $error("pin not toggled on A match");

   pwm_flag_p_a: assert property (is_pwm && p_hit |=> s.flag_p)
      else $error("P flag missed in pwm");

   clear_a_a: assert property (!is_pwm && cclr && a_hit && !wr_i |=> s.cnt == '0)
      else $error("counter not cleared on A match");

   pwm_period_a: assert property (is_pwm && dpx && a_hit && !wr_i |=> s.cnt == '0)
      else $error("pwm period not cleared by A");

   pwm_p_clear_a: assert property (is_pwm && !dpx && p_hit && !wr_i |=> s.cnt == '0)
      else $error("pwm period not cleared by P");

   count_up_a: assert property (s.run && !a_hit && !p_hit && !wr_i
      |=> s.cnt == CNT_W'($past(s.cnt) + 1'b1))
      else $error("running counter did not step");

   dpx_full_a: assert property (is_pwm && act == ACT_HIGH && dpx && s.cmp_p == '0 && !wr_i
      |=> s.lvl == oc)
      else $error("swap duty code zero not full");

   flag_p_set_a: assert property (!is_pwm && !cclr && p_hit |=> s.flag_p)
      else $error("P flag missed with P clear source");

   pwm_idle_a: assert property (is_pwm && act == ACT_NONE && !wr_i |=> s.lvl != oc)
      else $error("forced inactive level wrong");

   duty_on_a: assert property (is_pwm && act == ACT_HIGH && !dpx && s.cnt < s.cmp_a && !wr_i
      |=> s.lvl == oc)
      else $error("pwm not active below duty");

   duty_off_a: assert property (is_pwm && act == ACT_HIGH && !dpx && s.cnt >= s.cmp_a && !wr_i
      |=> s.lvl != oc)
      else $error("pwm active past duty");

endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stm_map.svh"
module tb_top
   import stm_pkg::*;
;
   logic        mclk_i  = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [2:0]  addr_i  = 3'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i    = 1'b0;
   logic        rd_i    = 1'b0;
   logic [15:0] rdata_o;
   logic        pin_o;
   logic        pin_oe_o;
   logic        fa;
   logic        fp;
   logic [15:0] v;
   logic [15:0] v2;
   int          fails      = 0;
   int          num_checks = 0;
   pin_action_t act[3] = '{ACT_LOW, ACT_HIGH, ACT_TOGGLE};
   logic        ocs[3] = '{1'b1, 1'b0, 1'b0};

   always #5 mclk_i = ~mclk_i;

   standard_timer_module #(.CNT_W(10), .P_W(3), .DATA_W(16)) standard_timer_module_inst (
      .mclk_i         (mclk_i),
      .rst_b_i        (rst_b_i),
      .addr_i         (addr_i),
      .wdata_i        (wdata_i),
      .wr_i           (wr_i),
      .rd_i           (rd_i),
      .rdata_o        (rdata_o),
      .pin_o          (pin_o),
      .pin_oe_o       (pin_oe_o),
      .match_a_flag_o (fa),
      .match_p_flag_o (fp)
   );

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   // settle delay keeps pin checks clear of the launching edge
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   function automatic logic [15:0] cw(mode_t m, pin_action_t a, logic oc, logic pol, logic dpx, logic cclr);
      return {8'h00, m, a, oc, pol, dpx, cclr};
   endfunction

   // stop first, control changes while running are undefined
   task automatic cfg(input logic [15:0] c, input logic [15:0] a, input logic [15:0] p);
      wr(`ADDR_RUN, 16'h0000);
      wr(`ADDR_FLAGS, 16'h0003);
      wr(`ADDR_CTRL, c);
      wr(`ADDR_CMP_A, a);
      wr(`ADDR_CMP_P, p);
      wr(`ADDR_RUN, 16'h0001);
   endtask

   // high cycles over one full period, independent of phase
   task automatic pwm(input logic [15:0] c, input logic [15:0] a, input logic [15:0] p, input int n, input int e);
      int k;
      k = 0;
      cfg(c, a, p);
      repeat (20) @(posedge mclk_i);
      repeat (n)
      begin
         @(negedge mclk_i);
         if (pin_o === 1'b1)
            k++;
      end
      chk("pwm_high", 16'(e), 16'(k));
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #500000;
      fails++;
      complete_run();
   end

   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(`ADDR_CTRL, v);
      chk("ctrl_reset", 16'h0000, v);
      rd(3'h6, v);
      chk("unmapped", 16'h0000, v);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         cfg(cw(MODE_COMPARE, act[i], ocs[i], 1'b0, 1'b0, 1'b1), 16'h00C8, 16'h0001);
         chk("pin_init", {15'h0000, ocs[i]}, {15'h0000, pin_o});
         repeat (210) @(negedge mclk_i);
         chk("pin_on_a", {15'h0000, ~ocs[i]}, {15'h0000, pin_o});
         chk("flag_a", 16'h0001, {15'h0000, fa});
         chk("no_flag_p", 16'h0000, {15'h0000, fp});
      end
      wr(`ADDR_FLAGS, 16'h0003);
      chk("flag_clr", 16'h0000, {15'h0000, fa});
      wr(`ADDR_RUN, 16'h0000);
      rd(`ADDR_COUNT, v);
      repeat (5) @(posedge mclk_i);
      rd(`ADDR_COUNT, v2);
      chk("cnt_hold", v, v2);
      wr(`ADDR_RUN, 16'h0001);
      rd(`ADDR_COUNT, v);
      chk("cnt_restart", 16'h0001, v);
      $display("test compare clear a done");
      cfg(cw(MODE_COMPARE, ACT_NONE, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0032, 16'h0001);
      repeat (140) @(negedge mclk_i);
      chk("both_flags", 16'h0003, {14'h0000, fp, fa});
      chk("pin_kept", 16'h0001, {15'h0000, pin_o});
      chk("oe_compare", 16'h0001, {15'h0000, pin_oe_o});
      cfg(cw(MODE_COMPARE, ACT_HIGH, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0000, 16'h0000);
      repeat (50) @(negedge mclk_i);
      chk("a_zero_flag", 16'h0000, {15'h0000, fa});
      rd(`ADDR_COUNT, v);
      chk("a_zero_run", 16'h0032, v);
      cfg(cw(MODE_TIMER, ACT_HIGH, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0005, 16'h0000);
      repeat (20) @(negedge mclk_i);
      chk("oe_timer", 16'h0000, {15'h0000, pin_oe_o});
      chk("flag_timer", 16'h0001, {15'h0000, fa});
      $display("test compare and timer done");
      pwm(cw(MODE_PWM, ACT_HIGH, 1'b1, 1'b0, 1'b0, 1'b1), 16'h0020, 16'h0001, 128, 32);
      chk("pwm_flags", 16'h0003, {14'h0000, fp, fa});
      pwm(cw(MODE_PWM, ACT_HIGH, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0100, 16'h0000, 1024, 256);
      pwm(cw(MODE_PWM, ACT_HIGH, 1'b1, 1'b1, 1'b0, 1'b0), 16'h0020, 16'h0001, 128, 96);
      pwm(cw(MODE_PWM, ACT_HIGH, 1'b1, 1'b0, 1'b0, 1'b0), 16'h00C8, 16'h0001, 128, 128);
      pwm(cw(MODE_PWM, ACT_HIGH, 1'b1, 1'b0, 1'b1, 1'b0), 16'h00C8, 16'h0001, 200, 128);
      pwm(cw(MODE_PWM, ACT_LOW, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0020, 16'h0001, 128, 128);
      pwm(cw(MODE_PWM, ACT_NONE, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0020, 16'h0001, 128, 0);
      $display("test pwm done");
      complete_run();
   end
endmodule
`default_nettype wire
